// file: tb/atm_cell_utopia_interface_bench.sv
// Self-checking bench of the ATM cell unit and UTOPIA link block
`timescale 1ns/1ps
`include "atm_utopia_map.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errors++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module atm_cell_utopia_interface_bench;
    logic                             mclk = 1'b0, rst = 1'b1, tx_ref_n = 1'b1;
    logic                             rx_clk = 1'b0, tx_clk = 1'b0;
    atm_utopia_pkg::if_cfg_t          cfg;
    atm_utopia_pkg::byte_strm_t [1:0] dfr, bs_tx, bs_rx;
    atm_utopia_pkg::cell_byte_t [1:0] frm;
    logic [1:0]                       insync;
    logic [1:0][15:0]                 hec_err;
    logic                             rx_ref_n, tx_ref_o, rx_enb_n, rx_soc, rx_oe, rx_clav;
    logic                             tx_enb_n, tx_soc, tx_clav, rx_clav_oe, tx_clav_oe;
    logic [4:0]                       addr = 5'h00;
    logic [7:0]                       rx_data, tx_data;
    integer                           errors = 0, checked = 0, seed = 32'h9b06;
    logic [31:0]                      hdr;
    bit                               ok;
    wire  [8:0]                       rx_bus = rx_oe ? {rx_soc, rx_data} : 'z;
    always #25 mclk = ~mclk;
    always #6 rx_clk = ~rx_clk;
    initial #3.7 forever #6 tx_clk = ~tx_clk;
    atm_utopia_if u_atm_utopia_if (
        .mclk_i(mclk), .rst_i(rst), .cfg_i(cfg), .dfr_i(dfr), .frm_o(frm), .bs_rx_o(bs_rx),
        .bs_tx_i(bs_tx), .insync_o(insync), .hec_err_o(hec_err), .rx_ref_n_o(rx_ref_n),
        .tx_ref_n_i(tx_ref_n), .tx_ref_n_o(tx_ref_o), .rx_clk_i(rx_clk), .rx_enb_n_i(rx_enb_n),
        .rx_addr_i(addr), .rx_data_o(rx_data), .rx_soc_o(rx_soc), .rx_data_oe_o(rx_oe),
        .rx_clav_o(rx_clav), .rx_clav_oe_o(rx_clav_oe), .tx_clk_i(tx_clk), .tx_enb_n_i(tx_enb_n),
        .tx_addr_i(addr), .tx_data_i(tx_data), .tx_soc_i(tx_soc), .tx_clav_o(tx_clav),
        .tx_clav_oe_o(tx_clav_oe));
    atm_layer_model u_atm_layer_model (
        .rx_clk_i(rx_clk), .rx_data_i(rx_bus[7:0]), .rx_soc_i(rx_bus[8]), .rx_clav_i(rx_clav),
        .rx_enb_n_o(rx_enb_n), .tx_clk_i(tx_clk), .tx_clav_i(tx_clav),
        .tx_enb_n_o(tx_enb_n), .tx_data_o(tx_data), .tx_soc_o(tx_soc));
    function automatic logic [7:0] hec(input logic [31:0] h);
        logic [7:0] c = 8'h00;
        for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ (c[7] ^ h[i] ? 8'h07 : 8'h00);
        return c ^ 8'h55;
    endfunction
    // Zero payload stays zero through the self-synchronising descrambler
    function automatic logic [7:0] cell_byte(input logic [31:0] h, input int i, input bit bad);
        if (i < 4) return h[31 - 8 * i -: 8];
        return i == 4 ? hec(h) ^ {7'h00, bad} : 8'h00;
    endfunction
    task automatic end_sim();
        if (errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic need(input bit c);
        `CHK(c, 1'b1)
        if (!c) end_sim();
    endtask
    // Takes one cell over the receive link and checks it against the fed cell
    task automatic get_cell();
        u_atm_layer_model.take_cell(ok);
        need(ok);
        for (int i = 0; i < `CELL_BYTES; i++) begin
            `CHK(u_atm_layer_model.rx_cell[i], cell_byte(hdr, i, 1'b0))
            `CHK(u_atm_layer_model.rx_sof[i], i == 0)
        end
        `CHK(u_atm_layer_model.clav_hold, 1'b1)
    endtask
    // Mode is only changed under reset since the link domains copy it late
    task automatic do_reset(input atm_utopia_pkg::if_mode_t m);
        @(posedge mclk);
        #1 rst = 1'b1;
        cfg = '{m, 1'b0, 5'h00, 5'h01};
        repeat (2) @(posedge mclk);
        #1;
        `CHK({rx_ref_n, tx_ref_o, rx_clav, tx_clav, rx_clav_oe, tx_clav_oe}, 6'h30)
        rst = 1'b0;
        repeat (10) @(posedge mclk);
        #1;
    endtask
    task automatic feed_cell(input bit bad);
        for (int i = 0; i < `CELL_BYTES; i++) begin
            dfr[0] = '{1'b1, cell_byte(hdr, i, bad)};
            @(posedge mclk);
            #1;
        end
        dfr[0].valid = 1'b0;
    endtask
    initial begin
        int n;
        {dfr, bs_tx} = '0;
        do_reset(atm_utopia_pkg::IF_UTOPIA1);
        hdr = $random(seed) | 32'h10;
        repeat (6) feed_cell(1'b0);
        `CHK(insync[0], 1'b1)
        get_cell();
        feed_cell(1'b1);
        `CHK({insync[0], hec_err[0]}, 17'h00001)
        for (int i = 0; i < `CELL_BYTES; i++) u_atm_layer_model.tx_cell[i] = 8'($random(seed));
        u_atm_layer_model.send_cell(ok);
        need(ok);
        for (n = 0; (frm[0].valid & frm[0].soc) !== 1'b1 && n < 4000; n++) @(negedge mclk);
        need(n < 4000);
        for (int i = 0; i < `CELL_BYTES; i++) begin
            `CHK(frm[0], {1'b1, i == 0, u_atm_layer_model.tx_cell[i]})
            `CHK(frm[1].valid, 1'b0)
            @(negedge mclk);
        end
        do_reset(atm_utopia_pkg::IF_BITSTREAM);
        repeat (40) begin
            dfr = 18'($random(seed));
            bs_tx = 18'($random(seed));
            @(posedge mclk);
            #1;
            `CHK(bs_rx, dfr)
            `CHK(frm, {bs_tx[1].valid, 1'b0, bs_tx[1].data, bs_tx[0].valid, 1'b0, bs_tx[0].data})
            `CHK({insync, rx_clav, tx_clav, rx_clav_oe, tx_clav_oe}, 6'h00)
        end
        for (n = 0; rx_ref_n !== 1'b0 && n < 3000; n++) @(negedge mclk);
        need(n < 3000);
        @(negedge mclk);
        for (n = 1; rx_ref_n !== 1'b0 && n < 3000; n++) @(negedge mclk);
        `CHK(n, `REF_CYCLES)
        @(posedge mclk);
        #1 tx_ref_n = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        `CHK(tx_ref_o, 1'b0)
        // Level 2: fast port at address 0, interleaved at 1, address 2 is another PHY
        do_reset(atm_utopia_pkg::IF_UTOPIA2);
        repeat (3) feed_cell(1'b0);
        for (int a = 0; a < 3; a++) begin
            @(posedge rx_clk);
            #1 addr = 5'(a);
            repeat (2) @(posedge rx_clk);
            #1;
            `CHK({rx_clav_oe, rx_clav}, {a < 2, a == 0})
            `CHK({tx_clav_oe, tx_clav}, {2{a < 2}})
        end
        @(posedge rx_clk);
        #1 addr = 5'h00;
        get_cell();
        end_sim();
    end
endmodule

// file: tb/atm_layer_model.sv
// Behavioural ATM layer controller on the UTOPIA receive and transmit links
`timescale 1ns/1ps
module atm_layer_model (
    // Receive link
    input  wire logic       rx_clk_i,
    input  wire logic [7:0] rx_data_i,
    input  wire logic       rx_soc_i,
    input  wire logic       rx_clav_i,
    output logic            rx_enb_n_o,
    // Transmit link
    input  wire logic       tx_clk_i,
    input  wire logic       tx_clav_i,
    output logic            tx_enb_n_o,
    output logic [7:0]      tx_data_o,
    output logic            tx_soc_o
);
    logic [7:0]  tx_cell [53];
    logic [7:0]  rx_cell [53];
    logic [52:0] rx_sof;
    logic        clav_hold;
    initial {rx_enb_n_o, tx_enb_n_o, tx_soc_o, tx_data_o} = 11'h600;
    // Flags are polled mid period so the value seen is the one the last edge launched
    task automatic take_cell(output bit ok);
        int n = 0;
        while (rx_clav_i !== 1'b1 && n < 4000) begin
            @(negedge rx_clk_i);
            n++;
        end
        ok = n < 4000;
        if (!ok) return;
        @(posedge rx_clk_i);
        #1 rx_enb_n_o = 1'b0;
        clav_hold = 1'b1;
        for (int i = 0; i < 53; i++) begin
            @(posedge rx_clk_i);
            #1 if (i == 52) rx_enb_n_o = 1'b1;
            @(negedge rx_clk_i);
            rx_cell[i] = rx_data_i;
            rx_sof[i] = rx_soc_i;
            if (i < 51) clav_hold &= rx_clav_i;
        end
    endtask
    task automatic send_cell(output bit ok);
        int n = 0;
        while (tx_clav_i !== 1'b1 && n < 4000) begin
            @(negedge tx_clk_i);
            n++;
        end
        ok = n < 4000;
        if (!ok) return;
        for (int i = 0; i < 54; i++) begin
            @(posedge tx_clk_i);
            #1 tx_enb_n_o = i == 53;
            tx_soc_o = i == 0;
            // Released data lines show a changed value, never the last byte
            tx_data_o = i == 53 ? ~tx_data_o : tx_cell[i % 53];
        end
    endtask
endmodule

// file: verilog/atm_utopia_if.sv
// ATM cell unit, cell FIFOs, UTOPIA L1/L2 link and bitstream bypass
`timescale 1ns/1ps
`include "atm_utopia_map.svh"
// Notes on behaviour
// - One byte per link clock; a cell is 53 consecutive byte transfers.
// - Eight-cell FIFO per channel and direction, fast and interleaved.
// - At most one of UTOPIA L1, UTOPIA L2 or bitstream port is enabled; none in IF_OFF.
// - Level 1 carries only one flow, fast or interleaved.
// - Level 1: sole PHY; Level 2: addressed ports, polling and selection.
// - Receive and transmit clocks are unrelated to each other and core.
// - Receive cell-available asserted for a ready cell, held during transfer.
// - With enable low, one byte is popped and presented each receive edge.
// - Receive start-of-cell marks only the first byte of a cell.
// - Receive data is 8 bits, bit 7 the most significant.
// - Transmit cell-available only with room for a whole cell; during a cell, only with room for one more.
// - Transmit data and start flag captured on edges with enable low.
// - Transmit data is 8 bits, bit 7 the most significant.
// - Device drives low-active 8 kHz receive reference; layer drives transmit one.
// - Non-cell streams bypass the cell FIFOs to the bitstream port.
// - Cell delineation, descrambling, idle filtering, HEC check, error count.
// - Cell unit idle while streams carry non-cell traffic.
// - Level 2 poll of our address is answered on cell-available next cycle.
module atm_utopia_if (
    // Core clock and reset
    input  wire logic                           mclk_i,
    input  wire logic                           rst_i,
    // Interface selection and port addresses, static while running
    input  wire atm_utopia_pkg::if_cfg_t        cfg_i,
    // Deframer streams and framer side, index 0 fast, 1 interleaved
    input  wire atm_utopia_pkg::byte_strm_t [1:0] dfr_i,
    output atm_utopia_pkg::cell_byte_t [1:0]    frm_o,
    // Synchronous bitstream port
    output atm_utopia_pkg::byte_strm_t [1:0]    bs_rx_o,
    input  wire atm_utopia_pkg::byte_strm_t [1:0] bs_tx_i,
    // Cell unit status
    output logic [1:0]                          insync_o,
    output logic [1:0][15:0]                    hec_err_o,
    // Reference clocks
    output logic                                rx_ref_n_o,
    input  wire logic                           tx_ref_n_i,
    output logic                                tx_ref_n_o,
    // UTOPIA receive link
    input  wire logic                           rx_clk_i,
    input  wire logic                           rx_enb_n_i,
    input  wire logic [4:0]                     rx_addr_i,
    output logic [7:0]                          rx_data_o,
    output logic                                rx_soc_o,
    output logic                                rx_data_oe_o,
    output logic                                rx_clav_o,
    output logic                                rx_clav_oe_o,
    // UTOPIA transmit link
    input  wire logic                           tx_clk_i,
    input  wire logic                           tx_enb_n_i,
    input  wire logic [4:0]                     tx_addr_i,
    input  wire logic [7:0]                     tx_data_i,
    input  wire logic                           tx_soc_i,
    output logic                                tx_clav_o,
    output logic                                tx_clav_oe_o
);
    function automatic logic [3:0] b2g(input logic [3:0] b);
        return b ^ (b >> 1);
    endfunction
    function automatic logic [3:0] g2b(input logic [3:0] g);
        logic [3:0] b;
        b = g;
        for (int i = 2; i >= 0; i--) b[i] = b[i+1] ^ g[i];
        return b;
    endfunction
    function automatic logic [7:0] hec_f(input logic [31:0] h);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 31; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ h[i]) ? `HEC_POLY : 8'h00);
        return r ^ `HEC_COSET;
    endfunction
    // Self-synchronising x^43+1 payload descrambler, MSB first
    function automatic logic [50:0] dscr_f(input logic [42:0] s, input logic [7:0] d);
        logic [42:0] t;
        logic [7:0]  o;
        t = s;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            o[i] = d[i] ^ t[42];
            t    = {t[41:0], d[i]};
        end
        return {t, o};
    endfunction

    // Link-domain resets: asserted at once, released on the link clock
    logic [1:0] rrst_reg;
    logic [1:0] trst_reg;
    always_ff @(posedge rx_clk_i or posedge rst_i) begin
        if (rst_i) rrst_reg <= 2'b11;
        else       rrst_reg <= {rrst_reg[0], 1'b0};
    end
    always_ff @(posedge tx_clk_i or posedge rst_i) begin
        if (rst_i) trst_reg <= 2'b11;
        else       trst_reg <= {trst_reg[0], 1'b0};
    end
    wire rrst = rrst_reg[1];
    wire trst = trst_reg[1];

    // Configuration is static, so a plain two-stage resync per domain suffices
    atm_utopia_pkg::if_cfg_t rcfg1_reg, rcfg_reg, tcfg1_reg, tcfg_reg;
    always_ff @(posedge rx_clk_i or posedge rrst) begin
        if (rrst) begin rcfg1_reg <= '0; rcfg_reg <= '0; end
        else      begin rcfg1_reg <= cfg_i; rcfg_reg <= rcfg1_reg; end
    end
    always_ff @(posedge tx_clk_i or posedge trst) begin
        if (trst) begin tcfg1_reg <= '0; tcfg_reg <= '0; end
        else      begin tcfg1_reg <= cfg_i; tcfg_reg <= tcfg1_reg; end
    end

    wire cell_mode = cfg_i.mode == atm_utopia_pkg::IF_UTOPIA1 ||
                     cfg_i.mode == atm_utopia_pkg::IF_UTOPIA2;
    wire bs_mode   = cfg_i.mode == atm_utopia_pkg::IF_BITSTREAM;
    wire rl1 = rcfg_reg.mode == atm_utopia_pkg::IF_UTOPIA1;
    wire rl2 = rcfg_reg.mode == atm_utopia_pkg::IF_UTOPIA2;
    wire tl1 = tcfg_reg.mode == atm_utopia_pkg::IF_UTOPIA1;
    wire tl2 = tcfg_reg.mode == atm_utopia_pkg::IF_UTOPIA2;
    wire rm_f = rl2 && rx_addr_i == rcfg_reg.addr_fast;
    wire rm_i = rl2 && rx_addr_i == rcfg_reg.addr_intl;
    wire tm_f = tl2 && tx_addr_i == tcfg_reg.addr_fast;
    wire tm_i = tl2 && tx_addr_i == tcfg_reg.addr_intl;

    logic [1:0]      rstat, tstat;
    logic [1:0][5:0] roff;
    logic [1:0][7:0] rdat;
    logic            rsel_reg, rok_reg, tsel_reg, tok_reg;
    wire rpop = !rx_enb_n_i && rok_reg && rstat[rsel_reg];
    wire tcap = !tx_enb_n_i && tok_reg;

    generate
        for (genvar c = 0; c < 2; c++) begin : g_ch
            // Receive direction: cell unit and FIFO write side on the core clock
            logic [7:0]  rmem [0:511];
            logic [39:0] win_reg;
            logic [42:0] ds_reg;
            logic [5:0]  woff_reg;
            logic [3:0]  wp_reg, wpg_reg, rpg1_reg, rpg2_reg, rd_g_reg, frg_reg;
            logic        keep_reg, sync_reg;
            logic [15:0] err_reg;
            atm_utopia_pkg::delin_t st_reg;
            wire        on    = cell_mode && (cfg_i.mode == atm_utopia_pkg::IF_UTOPIA2 ||
                                              cfg_i.l1_intl == c);
            wire        vin   = on && dfr_i[c].valid;
            wire [39:0] win   = {win_reg[31:0], dfr_i[c].data};
            wire        hec_ok = hec_f(win[39:8]) == win[7:0];
            wire        idle  = win[39:8] == `IDLE_HDR || win[39:8] == `UNASSIGNED_HDR;
            wire [50:0] dsn   = dscr_f(ds_reg, dfr_i[c].data);
            wire [3:0]  used  = wp_reg - g2b(rpg2_reg);
            wire        full  = used == `FIFO_CELLS;
            wire        wr    = vin && st_reg == atm_utopia_pkg::DL_SYNC && !full;
            wire        paylo = woff_reg > `HDR_LAST;
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    st_reg <= atm_utopia_pkg::DL_HUNT;
                    win_reg <= 40'h0000000000;
                    ds_reg <= '0;
                    woff_reg <= 6'h00;
                    keep_reg <= 1'b0;
                    wp_reg <= 4'h0;
                    err_reg <= 16'h0000;
                end else if (!on) begin
                    st_reg <= atm_utopia_pkg::DL_HUNT;
                end else if (vin) begin
                    win_reg <= win;
                    if (st_reg == atm_utopia_pkg::DL_HUNT) begin
                        if (hec_ok) begin
                            st_reg <= atm_utopia_pkg::DL_SYNC;
                            woff_reg <= `HDR_LAST + 6'h01;
                            keep_reg <= 1'b0;
                        end
                    end else begin
                        woff_reg <= (woff_reg == `CELL_LAST) ? 6'h00 : woff_reg + 6'h01;
                        if (paylo) ds_reg <= dsn[50:8];
                        if (woff_reg == `HDR_LAST) begin
                            keep_reg <= hec_ok && !idle;
                            if (!hec_ok) begin
                                st_reg <= atm_utopia_pkg::DL_HUNT;
                                err_reg <= err_reg + 16'h0001;
                            end
                        end
                        if (woff_reg == `CELL_LAST && keep_reg && !full) wp_reg <= wp_reg + 4'h1;
                    end
                end
            end
            always_ff @(posedge mclk_i) begin
                if (wr) rmem[{wp_reg[2:0], woff_reg}] <= paylo ? dsn[7:0] : dfr_i[c].data;
            end
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    wpg_reg <= 4'h0; rpg1_reg <= 4'h0; rpg2_reg <= 4'h0; sync_reg <= 1'b0;
                end else begin
                    wpg_reg <= b2g(wp_reg);
                    rpg1_reg <= rd_g_reg;
                    rpg2_reg <= rpg1_reg;
                    sync_reg <= st_reg == atm_utopia_pkg::DL_SYNC;
                end
            end
            assign insync_o[c]  = sync_reg;
            assign hec_err_o[c] = err_reg;

            // Receive direction: FIFO read side on the receive clock
            logic [3:0] rd_reg, wg1_reg, wg2_reg;
            logic [5:0] ro_reg;
            wire        rgo = rpop && rsel_reg == c;
            assign rstat[c] = (g2b(wg2_reg) != rd_reg) || ro_reg != 6'h00;
            assign roff[c]  = ro_reg;
            assign rdat[c]  = rmem[{rd_reg[2:0], ro_reg}];
            always_ff @(posedge rx_clk_i or posedge rrst) begin
                if (rrst) begin
                    rd_reg <= 4'h0; rd_g_reg <= 4'h0; ro_reg <= 6'h00;
                    wg1_reg <= 4'h0; wg2_reg <= 4'h0;
                end else begin
                    wg1_reg <= wpg_reg;
                    wg2_reg <= wg1_reg;
                    rd_g_reg <= b2g(rd_reg);
                    if (rgo) begin
                        ro_reg <= (ro_reg == `CELL_LAST) ? 6'h00 : ro_reg + 6'h01;
                        if (ro_reg == `CELL_LAST) rd_reg <= rd_reg + 4'h1;
                    end
                end
            end

            // Transmit direction: capture on the transmit clock
            logic [7:0] tmem [0:511];
            logic [3:0] tw_reg, twg_reg, trg1_reg, trg2_reg;
            logic [5:0] to_reg;
            logic       inc_reg;
            wire [3:0]  tused = tw_reg - g2b(trg2_reg);
            wire        room1 = tused < `FIFO_CELLS;
            wire        room2 = tused < `FIFO_CELLS - 4'h1;
            wire        tgo   = tcap && tsel_reg == c;
            wire        twr   = tgo && (tx_soc_i ? room1 : inc_reg);
            assign tstat[c] = inc_reg ? room2 : room1;
            always_ff @(posedge tx_clk_i or posedge trst) begin
                if (trst) begin
                    tw_reg <= 4'h0; twg_reg <= 4'h0; to_reg <= 6'h00; inc_reg <= 1'b0;
                    trg1_reg <= 4'h0; trg2_reg <= 4'h0;
                end else begin
                    trg1_reg <= frg_reg;
                    trg2_reg <= trg1_reg;
                    twg_reg <= b2g(tw_reg);
                    if (twr) begin
                        to_reg  <= tx_soc_i ? 6'h01 : to_reg + 6'h01;
                        inc_reg <= tx_soc_i || to_reg != `CELL_LAST;
                        if (!tx_soc_i && to_reg == `CELL_LAST) tw_reg <= tw_reg + 4'h1;
                    end
                end
            end
            always_ff @(posedge tx_clk_i) begin
                if (twr) tmem[{tw_reg[2:0], tx_soc_i ? 6'h00 : to_reg}] <= tx_data_i;
            end

            // Transmit direction: drain to the framer on the core clock
            logic [3:0] fr_reg, twg1_reg, twg2_reg;
            logic [5:0] fo_reg;
            atm_utopia_pkg::cell_byte_t frm_reg;
            atm_utopia_pkg::byte_strm_t bs_reg;
            wire        favail = cell_mode && g2b(twg2_reg) != fr_reg;
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    fr_reg <= 4'h0; frg_reg <= 4'h0; fo_reg <= 6'h00;
                    twg1_reg <= 4'h0; twg2_reg <= 4'h0; frm_reg <= '0; bs_reg <= '0;
                end else begin
                    twg1_reg <= twg_reg;
                    twg2_reg <= twg1_reg;
                    frg_reg <= b2g(fr_reg);
                    bs_reg <= bs_mode ? dfr_i[c] : '0;
                    if (bs_mode) frm_reg <= {bs_tx_i[c].valid, 1'b0, bs_tx_i[c].data};
                    else frm_reg <= {favail, favail && fo_reg == 6'h00,
                                     tmem[{fr_reg[2:0], fo_reg}]};
                    if (favail) begin
                        fo_reg <= (fo_reg == `CELL_LAST) ? 6'h00 : fo_reg + 6'h01;
                        if (fo_reg == `CELL_LAST) fr_reg <= fr_reg + 4'h1;
                    end
                end
            end
            assign frm_o[c]   = frm_reg;
            assign bs_rx_o[c] = bs_reg;

            fifo_depth_a: assert property (@(posedge mclk_i) disable iff (rst_i)
                used <= `FIFO_CELLS) else $error("receive FIFO holds more than eight cells");
            cell_idle_a: assert property (@(posedge mclk_i) disable iff (rst_i)
                !on |=> st_reg == atm_utopia_pkg::DL_HUNT && !wr)
                else $error("cell unit active without cell traffic");
            bypass_a: assert property (@(posedge mclk_i) disable iff (rst_i)
                bs_mode && dfr_i[c].valid |=> bs_reg.valid && bs_reg.data == $past(dfr_i[c].data))
                else $error("bitstream byte not bypassed");
        end
    endgenerate

    // Receive link: selection, cell-available answer and byte output
    always_ff @(posedge rx_clk_i or posedge rrst) begin
        if (rrst) begin
            rsel_reg <= 1'b0; rok_reg <= 1'b0;
            rx_data_o <= 8'h00; rx_soc_o <= 1'b0; rx_data_oe_o <= 1'b0;
            rx_clav_o <= 1'b0; rx_clav_oe_o <= 1'b0;
        end else begin
            if (rl1) begin
                rsel_reg <= rcfg_reg.l1_intl; rok_reg <= 1'b1;
            end else if (!rl2) rok_reg <= 1'b0;
            else if (rx_enb_n_i) begin
                rsel_reg <= !rm_f; rok_reg <= rm_f || rm_i;
            end
            if (rpop) rx_data_o <= rdat[rsel_reg];
            rx_soc_o     <= rpop && roff[rsel_reg] == 6'h00;
            rx_data_oe_o <= !rx_enb_n_i && rok_reg;
            rx_clav_o    <= rl1 ? rstat[rcfg_reg.l1_intl] :
                            (rm_f ? rstat[0] : (rm_i && rstat[1]));
            rx_clav_oe_o <= rl1 || rm_f || rm_i;
        end
    end

    // Transmit link: selection and cell-available answer
    always_ff @(posedge tx_clk_i or posedge trst) begin
        if (trst) begin
            tsel_reg <= 1'b0; tok_reg <= 1'b0; tx_clav_o <= 1'b0; tx_clav_oe_o <= 1'b0;
        end else begin
            if (tl1) begin
                tsel_reg <= tcfg_reg.l1_intl; tok_reg <= 1'b1;
            end else if (!tl2) tok_reg <= 1'b0;
            else if (tx_enb_n_i) begin
                tsel_reg <= !tm_f; tok_reg <= tm_f || tm_i;
            end
            tx_clav_o    <= tl1 ? tstat[tcfg_reg.l1_intl] :
                            (tm_f ? tstat[0] : (tm_i && tstat[1]));
            tx_clav_oe_o <= tl1 || tm_f || tm_i;
        end
    end

    // 8 kHz reference: local low pulse out, far one resynchronised
    logic [11:0] ref_reg;
    logic        tref1_reg;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_reg <= 12'h000; rx_ref_n_o <= 1'b1; tref1_reg <= 1'b1; tx_ref_n_o <= 1'b1;
        end else begin
            ref_reg    <= (ref_reg == 12'(`REF_CYCLES - 1)) ? 12'h000 : ref_reg + 12'h001;
            rx_ref_n_o <= ref_reg != 12'(`REF_CYCLES - 1);
            tref1_reg  <= tx_ref_n_i;
            tx_ref_n_o <= tref1_reg;
        end
    end

    sequence rx_take_s;
        !rx_enb_n_i && rok_reg && rstat[rsel_reg];
    endsequence
    rx_pop_a: assert property (@(posedge rx_clk_i) disable iff (rrst)
        rx_take_s |=> rx_data_oe_o) else $error("popped byte not driven");
    rx_soc_a: assert property (@(posedge rx_clk_i) disable iff (rrst)
        rx_soc_o |-> $past(rpop) && $past(roff[rsel_reg]) == 6'h00)
        else $error("start of cell on a non-first byte");
    rx_hold_a: assert property (@(posedge rx_clk_i) disable iff (rrst)
        rl1 && $stable(rl1) && roff[rcfg_reg.l1_intl] != 6'h00 |=> rx_clav_o)
        else $error("cell-available dropped mid cell");
    tx_room_a: assert property (@(posedge tx_clk_i) disable iff (trst)
        tl1 && !tstat[tcfg_reg.l1_intl] |=> !tx_clav_o)
        else $error("transmit cell-available without room");
    poll_a: assert property (@(posedge rx_clk_i) disable iff (rrst)
        rm_f |=> rx_clav_oe_o ##0 rx_clav_o == $past(rstat[0]))
        else $error("poll not answered next cycle");
    ref_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        $fell(rx_ref_n_o) |=> rx_ref_n_o [*8]) else $error("reference pulse too wide");
endmodule

// file: verilog/atm_utopia_map.svh
// Constants of the ATM cell and UTOPIA interface block
`ifndef ATM_UTOPIA_MAP_SVH
`define ATM_UTOPIA_MAP_SVH
`define CELL_BYTES     53
`define CELL_LAST      6'h34
`define HDR_LAST       6'h04
`define FIFO_CELLS     4'h8
`define FIFO_BYTES     424
`define HEC_POLY       8'h07
`define HEC_COSET      8'h55
`define IDLE_HDR       32'h00000001
`define UNASSIGNED_HDR 32'h00000000
`define REF_PERIOD_NS  125000
`define MCLK_PERIOD_NS 50
`define REF_CYCLES     (`REF_PERIOD_NS / `MCLK_PERIOD_NS)
`endif

// file: verilog/atm_utopia_pkg.sv
// Types shared by the ATM cell and UTOPIA interface block
package atm_utopia_pkg;
    typedef enum logic [1:0] {
        IF_UTOPIA1   = 2'b00,
        IF_UTOPIA2   = 2'b01,
        IF_BITSTREAM = 2'b10,
        IF_OFF       = 2'b11
    } if_mode_t;
    typedef enum logic {
        DL_HUNT = 1'b0,
        DL_SYNC = 1'b1
    } delin_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_strm_t;
    typedef struct packed {
        logic       valid;
        logic       soc;
        logic [7:0] data;
    } cell_byte_t;
    typedef struct packed {
        if_mode_t   mode;
        logic       l1_intl;
        logic [4:0] addr_fast;
        logic [4:0] addr_intl;
    } if_cfg_t;
endpackage
